// ==== hw/dpc_defines.vh ====
// constants for the display plane configuration and controller port block
// assumes an 8-bit i/o bus whose base decode is done outside this block
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

// i/o port offsets from the board base
`define DPC_OFS_CONFIG 3'h3
`define DPC_OFS_SUB_PTR 3'h4
`define DPC_OFS_SUB_DATA 3'h5
`define DPC_OFS_DIR_PTR 3'h6
`define DPC_OFS_DIR_DATA 3'h7

// configuration register fields and reset value
`define DPC_CFG_WE_LSB 0
`define DPC_CFG_WE_MSB 3
`define DPC_CFG_RSEL_LSB 4
`define DPC_CFG_RSEL_MSB 5
`define DPC_CFG_LAY_LSB 6
`define DPC_CFG_LAY_MSB 7
`define DPC_CFG_RESET 8'h00

// memory layout codes
`define DPC_LAY_FIVE 2'b00
`define DPC_LAY_FOUR 2'b01
`define DPC_LAY_THREE 2'b10

// host memory windows (20-bit host addresses) and 18-bit physical sizes and bases
`define DPC_WIN_BASE 20'hA_0000
`define DPC_WIN_BASE_THREE 20'hA_4000
`define DPC_PLANE_32K 18'h0_8000
`define DPC_PLANE_40K 18'h0_A000
`define DPC_SHARE_16K 18'h0_4000
`define DPC_CRTC_BUF_BASE_FIVE 18'h2_0000
`define DPC_CRTC_BUF_SIZE 18'h0_8000
`define DPC_PHYS_SIZE 18'h2_8000

// crt controller register indices
`define DPC_IDX_LAST_SUB 5'h0B
`define DPC_IDX_LAST_PLAIN 5'h0D
`define DPC_IDX_CURSOR_LOW 5'h0F
`define DPC_IDX_PTR_BITS 5

// monitor modes selecting the substitution column
`define DPC_MON_MONO 2'b00
`define DPC_MON_A40 2'b01
`define DPC_MON_A80 2'b10
`define DPC_MON_GFX 2'b11

`endif

// ==== hw/dpc_plane_config.v ====
// display plane configuration register, host and graphics controller plane
// steering, memory layout mapping and the crt controller port pair logic.
// assumes base address decode outside; io strobes are one-cycle pulses
// synchronous to clk_sys, and memory accepts plane enables in the next cycle.
//
// Function
// - config register write-only at base offset three
// - bits 0-3 are per-plane write enables
// - bits 4-5 pick one plane for host reads
// - no host read when all write enables zero
// - read select governs host accesses only
// - controller reads pick plane from A16/A17
// - graphics planes share one window, at A0000 or at A4000 in code 10
// - bits 6-7 choose physical memory layout
// - code 00 four 32K planes, separate buffer
// - code 01 40K planes, buffer over plane 0
// - code 10 window at A4000, 16K shared
// - three-plane layout disables plane 3
// - crt buffer limited to 32K bytes
// - offsets four/five writes get substituted data
// - offsets six/seven writes pass unchanged
// - table holds per-mode timing replacement values
// - writes only to indices 00 through 0F
// - plane colour direct only in digital variant
// - indices twelve to seventeen never substituted
// - pointer latches five low data bits
`timescale 1ns/1ps
`include "dpc_defines.vh"

module dpc_plane_config (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // host i/o port, offset within board base
  input wire [2:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  // strap and mode inputs
  input wire [1:0] mon_mode,
  input wire analog_variant,
  // host display memory access
  input wire host_req,
  input wire host_we,
  input wire [19:0] host_addr,
  output reg [3:0] host_plane_we,
  output reg [3:0] host_plane_re,
  output reg [17:0] host_phys_addr,
  output reg host_hit,
  // graphics_display_controller memory access
  input wire gdc_req,
  input wire gdc_we,
  input wire [17:0] gdc_addr,
  output reg [3:0] gdc_plane_we,
  output reg [3:0] gdc_plane_re,
  output reg [17:0] gdc_phys_addr,
  // crt controller buffer access
  input wire crtc_mem_req,
  input wire [14:0] crtc_mem_addr,
  output reg [17:0] crtc_phys_addr,
  output reg crtc_phys_valid,
  // crt controller register port
  output reg crtc_reg_wr,
  output reg [4:0] crtc_reg_idx,
  output reg [7:0] crtc_reg_data,
  // layout status
  output reg [7:0] config_view,
  output reg plane_colour_direct
);

  // configuration register and its fields
  reg [7:0] mem_cfg; // plane config
  wire [3:0] cfg_we; // write enables
  wire [1:0] cfg_rsel; // host read plane
  wire [1:0] cfg_lay; // layout code
  // pointer registers
  reg [4:0] sub_ptr; // substituted pair pointer
  reg [4:0] dir_ptr; // direct pair pointer
  // combinational next values
  reg [3:0] next_host_we;
  reg [3:0] next_host_re;
  reg [17:0] next_host_phys;
  reg next_host_hit;
  reg [3:0] next_gdc_we;
  reg [3:0] next_gdc_re;
  reg [17:0] next_gdc_phys;
  reg [17:0] next_crtc_phys;
  reg [7:0] next_sub_data;
  reg [19:0] win_off; // offset into host window
  reg [17:0] plane_sz; // bytes per plane
  reg [17:0] plane_skip; // hidden head of each plane

  assign cfg_we = mem_cfg[`DPC_CFG_WE_MSB:`DPC_CFG_WE_LSB];
  assign cfg_rsel = mem_cfg[`DPC_CFG_RSEL_MSB:`DPC_CFG_RSEL_LSB];
  assign cfg_lay = mem_cfg[`DPC_CFG_LAY_MSB:`DPC_CFG_LAY_LSB];

  // plane number to one-hot
  function [3:0] one_hot;
    input [1:0] sel;
    begin
      one_hot = 4'h1 << sel;
    end
  endfunction

  // planes usable in a layout; three-plane layout drops the intensity plane
  function [3:0] plane_mask;
    input [1:0] lay;
    begin
      if (lay == `DPC_LAY_THREE) begin
        plane_mask = 4'h7;
      end else begin
        plane_mask = 4'hF;
      end
    end
  endfunction

  // plane size by layout
  function [17:0] size_of;
    input [1:0] lay;
    begin
      case (lay)
        `DPC_LAY_FOUR: size_of = `DPC_PLANE_40K;
        `DPC_LAY_THREE: size_of = `DPC_PLANE_40K;
        default: size_of = `DPC_PLANE_32K;
      endcase
    end
  endfunction

  // physical address of a byte in a plane
  function [17:0] phys_of;
    input [1:0] plane;
    input [17:0] size;
    input [17:0] off;
    reg [17:0] base;
    begin
      case (plane)
        2'd0: base = 18'h0_0000;
        2'd1: base = size;
        2'd2: base = size + size;
        default: base = size + size + size;
      endcase
      phys_of = base + off;
    end
  endfunction

  // replacement timing values per monitor mode, indices 00 to 0B
  function [7:0] sub_value;
    input [1:0] mode;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: sub_value = (mode == `DPC_MON_MONO || mode == `DPC_MON_A80) ? 8'h67 : 8'h33;
        5'h01: sub_value = (mode == `DPC_MON_MONO || mode == `DPC_MON_A80) ? 8'h50 : 8'h28;
        5'h02: sub_value = (mode == `DPC_MON_MONO || mode == `DPC_MON_A80) ? 8'h56 : 8'h2B;
        5'h03: sub_value = 8'h06;
        5'h04: sub_value = (mode == `DPC_MON_GFX) ? 8'h7F : 8'h1F;
        5'h05: sub_value = 8'h09;
        5'h06: sub_value = (mode == `DPC_MON_GFX) ? 8'h64 : 8'h19;
        5'h07: sub_value = (mode == `DPC_MON_GFX) ? 8'h70 : 8'h1C;
        5'h08: sub_value = 8'h02;
        5'h09: sub_value = (mode == `DPC_MON_GFX) ? 8'h03 : 8'h0F;
        5'h0A: sub_value = 8'h0C;
        default: sub_value = 8'h0E;
      endcase
    end
  endfunction

  // write strobe aimed at one port offset
  function port_hit;
    input wr;
    input [2:0] addr;
    input [2:0] ofs;
    begin
      port_hit = wr && (addr == ofs);
    end
  endfunction

  // crt register indices that accept a host write
  function idx_writable;
    input [4:0] idx;
    begin
      idx_writable = (idx <= `DPC_IDX_CURSOR_LOW);
    end
  endfunction

  // pointers keep only five bits, so a high index byte still selects a
  // register; anything past the cursor pair is dropped at the data port
  // configuration and pointer writes
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_cfg <= `DPC_CFG_RESET;
      sub_ptr <= 5'h00;
      dir_ptr <= 5'h00;
    end else if (io_wr) begin
      case (io_addr)
        `DPC_OFS_CONFIG: mem_cfg <= io_wdata;
        `DPC_OFS_SUB_PTR: sub_ptr <= io_wdata[`DPC_IDX_PTR_BITS-1:0];
        `DPC_OFS_DIR_PTR: dir_ptr <= io_wdata[`DPC_IDX_PTR_BITS-1:0];
        default: begin
          mem_cfg <= mem_cfg;
        end
      endcase
    end
  end

  // substituted data: table value for timing indices, host data otherwise
  always @* begin
    if (sub_ptr <= `DPC_IDX_LAST_SUB) begin
      next_sub_data = sub_value(mon_mode, sub_ptr);
    end else begin
      next_sub_data = io_wdata;
    end
  end

  // crt controller register writes
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      crtc_reg_wr <= 1'b0;
      crtc_reg_idx <= 5'h00;
      crtc_reg_data <= 8'h00;
    end else begin
      crtc_reg_wr <= 1'b0;
      if (port_hit(io_wr, io_addr, `DPC_OFS_SUB_DATA) && idx_writable(sub_ptr)) begin
        crtc_reg_wr <= 1'b1;
        crtc_reg_idx <= sub_ptr;
        crtc_reg_data <= next_sub_data;
      end else if (port_hit(io_wr, io_addr, `DPC_OFS_DIR_DATA) &&
                   idx_writable(dir_ptr)) begin
        crtc_reg_wr <= 1'b1;
        crtc_reg_idx <= dir_ptr;
        crtc_reg_data <= io_wdata;
      end
    end
  end

  // host read data: all ports here are write-only and read as zero
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= 8'h00;
    end
  end

  // the base is subtracted first; an address below the base wraps to a
  // large offset, so the lower bound is checked on its own
  // host window decode and plane steering
  always @* begin
    plane_sz = size_of(cfg_lay);
    plane_skip = 18'h0_0000;
    next_host_hit = 1'b0;
    next_host_we = 4'h0;
    next_host_re = 4'h0;
    next_host_phys = 18'h0_0000;
    win_off = 20'h0_0000;
    if (cfg_lay == `DPC_LAY_THREE) begin
      win_off = host_addr - `DPC_WIN_BASE_THREE;
      plane_skip = `DPC_SHARE_16K;
      next_host_hit = (host_addr >= `DPC_WIN_BASE_THREE) &&
                      (win_off[17:0] < plane_sz - plane_skip) && (win_off[19:18] == 2'b00);
    end else begin
      win_off = host_addr - `DPC_WIN_BASE;
      next_host_hit = (host_addr >= `DPC_WIN_BASE) &&
                      (win_off[17:0] < plane_sz) && (win_off[19:18] == 2'b00);
    end
    next_host_hit = next_host_hit && host_req;
    if (next_host_hit) begin
      next_host_phys = phys_of(cfg_rsel, plane_sz, win_off[17:0] + plane_skip);
      if (host_we) begin
        next_host_we = cfg_we & plane_mask(cfg_lay);
      end else if (cfg_we != 4'h0) begin
        next_host_re = one_hot(cfg_rsel) & plane_mask(cfg_lay);
      end
    end
  end

  // the controller reads by its own address bits, never by the host read
  // select, so host and controller may read different planes at once
  // graphics controller plane steering
  always @* begin
    next_gdc_we = 4'h0;
    next_gdc_re = 4'h0;
    next_gdc_phys = phys_of(gdc_addr[17:16], size_of(cfg_lay), {2'b00, gdc_addr[15:0]});
    if (gdc_req) begin
      if (gdc_we) begin
        next_gdc_we = cfg_we & plane_mask(cfg_lay);
      end else begin
        next_gdc_re = one_hot(gdc_addr[17:16]) & plane_mask(cfg_lay);
      end
    end
  end

  // in the four- and three-plane layouts the buffer lands on plane 0;
  // host software must keep the crt side idle in the four-plane layout
  // crt buffer placement, never more than 32K
  always @* begin
    case (cfg_lay)
      `DPC_LAY_FOUR: next_crtc_phys = {3'b000, crtc_mem_addr};
      `DPC_LAY_THREE: next_crtc_phys = {3'b000, crtc_mem_addr};
      default: next_crtc_phys = `DPC_CRTC_BUF_BASE_FIVE + {3'b000, crtc_mem_addr};
    endcase
  end

  // memory sees settled enables one cycle after each request
  // registered memory steering outputs
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      host_plane_we <= 4'h0;
      host_plane_re <= 4'h0;
      host_phys_addr <= 18'h0_0000;
      host_hit <= 1'b0;
      gdc_plane_we <= 4'h0;
      gdc_plane_re <= 4'h0;
      gdc_phys_addr <= 18'h0_0000;
      crtc_phys_addr <= 18'h0_0000;
      crtc_phys_valid <= 1'b0;
    end else begin
      host_plane_we <= next_host_we;
      host_plane_re <= next_host_re;
      host_phys_addr <= next_host_phys;
      host_hit <= next_host_hit;
      gdc_plane_we <= next_gdc_we;
      gdc_plane_re <= next_gdc_re;
      gdc_phys_addr <= next_gdc_phys;
      crtc_phys_addr <= next_crtc_phys;
      crtc_phys_valid <= crtc_mem_req;
    end
  end

  // plane colours are direct only on the digital board
  // status view of the configuration and colour interpretation
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      config_view <= `DPC_CFG_RESET;
      plane_colour_direct <= 1'b0;
    end else begin
      config_view <= mem_cfg;
      plane_colour_direct <= ~analog_variant;
    end
  end

endmodule // dpc_plane_config

// ==== tb/dpc_plane_config_asserts.sv ====
// checker for the plane configuration block ports
// assumes a bind onto dpc_plane_config, one clock domain
`timescale 1ns/1ps
module dpc_plane_config_asserts (
  // clock and reset
  input wire clk_sys,
  input wire rstn,
  // i/o port
  input wire [2:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  // plane steering
  input wire gdc_req,
  input wire gdc_we,
  input wire [17:0] gdc_addr,
  input wire [3:0] gdc_plane_we,
  input wire [3:0] gdc_plane_re,
  input wire [3:0] host_plane_re,
  // register port and status
  input wire [7:0] config_view,
  input wire crtc_reg_wr,
  input wire [4:0] crtc_reg_idx,
  input wire [7:0] crtc_reg_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // shadows of the config and both pointers
  logic [7:0] cfg;
  logic [4:0] sptr;
  logic [4:0] dptr;
  wire [1:0] gsel = gdc_addr[17:16];
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg <= 8'h00;
      sptr <= 5'h00;
      dptr <= 5'h00;
    end else if (io_wr) begin
      if (io_addr == 3'h3) cfg <= io_wdata;
      if (io_addr == 3'h4) sptr <= io_wdata[4:0];
      if (io_addr == 3'h6) dptr <= io_wdata[4:0];
    end
  end
  property p_rd_zero;
    io_rd |=> io_rdata == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("bad rdata");
  property p_cfg_view;
    io_wr && io_addr == 3'h3 |-> ##2 config_view == $past(io_wdata, 2); endproperty
  a_cfg_view: assert property (p_cfg_view) else $error("bad config");
  property p_dir;
    io_wr && io_addr == 3'h7 && !dptr[4] |=> crtc_reg_wr && crtc_reg_data == $past(io_wdata)
      && crtc_reg_idx == $past(dptr); endproperty
  a_dir: assert property (p_dir) else $error("direct write lost");
  property p_refuse;
    io_wr && io_addr[0] && io_addr[2] && (io_addr[1] ? dptr[4] : sptr[4]) |=> !crtc_reg_wr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("high index written");
  property p_pass;
    io_wr && io_addr == 3'h5 && sptr[4:2] == 3'b011 |=> crtc_reg_wr
      && crtc_reg_data == $past(io_wdata) && crtc_reg_idx == $past(sptr); endproperty
  a_pass: assert property (p_pass) else $error("pass value changed");
  property p_pulse;
    crtc_reg_wr |-> $past(io_wr) && ($past(io_addr) & 3'h5) == 3'h5; endproperty
  a_pulse: assert property (p_pulse) else $error("stray write");
  property p_onehot;
    $onehot0(host_plane_re) && $onehot0(gdc_plane_re); endproperty
  a_onehot: assert property (p_onehot) else $error("multi plane read");
  property p_gdc;
    gdc_req && !gdc_we && cfg[7:6] != 2'b10 |=> gdc_plane_re == 4'h1 << $past(gsel);
  endproperty
  a_gdc: assert property (p_gdc) else $error("bad gdc plane");
  property p_three;
    cfg[7:6] == 2'b10 |=> !gdc_plane_we[3]; endproperty
  a_three: assert property (p_three) else $error("plane 3 written");
  c_reg: cover property (crtc_reg_wr);
  c_gdc: cover property (gdc_plane_re != 4'h0);
  c_three: cover property (cfg[7:6] == 2'b10);
endmodule // dpc_plane_config_asserts
bind dpc_plane_config dpc_plane_config_asserts u_chk (.*);

// ==== tb/dpc_host_model.sv ====
// host processor model on the board's i/o ports
// assumes strobes change on the falling edge of clk_sys
`timescale 1ns/1ps
module dpc_host_model (
  // clock
  input wire clk_sys,
  // i/o bus towards the board
  output logic [2:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // idle bus at time zero
  initial begin
    io_addr = 3'h0;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // one write, data line inverted once released
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask
  // one read strobe
  task rd(input logic [2:0] a);
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
  endtask
endmodule // dpc_host_model

// ==== tb/dpc_plane_config_tb.sv ====
// self-checking bench for the plane configuration block
// assumes host model and checker compiled first
`timescale 1ns/1ps
module dpc_plane_config_tb;
  // stimulus
  logic clk_sys, rstn, analog_variant, host_req, host_we, gdc_req, gdc_we, crtc_mem_req;
  logic [1:0] mon_mode;
  logic [19:0] host_addr;
  logic [17:0] gdc_addr;
  logic [14:0] crtc_mem_addr;
  // design outputs and host bus
  wire [2:0] io_addr;
  wire io_wr, io_rd, host_hit, crtc_phys_valid, crtc_reg_wr, plane_colour_direct;
  wire [7:0] io_wdata, io_rdata, crtc_reg_data, config_view;
  wire [3:0] host_plane_we, host_plane_re, gdc_plane_we, gdc_plane_re;
  wire [17:0] host_phys_addr, gdc_phys_addr, crtc_phys_addr;
  wire [4:0] crtc_reg_idx;
  int n_mismatch, tests_run, cyc;
  dpc_plane_config DUT (.*);
  dpc_host_model host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one memory cycle on host, gdc and crtc sides
  task acc(input logic h, w, g, c, input logic [19:0] ha, input logic [17:0] ga);
    @(negedge clk_sys);
    host_req = h;
    host_we = w;
    host_addr = ha;
    gdc_req = g;
    gdc_we = w;
    gdc_addr = ga;
    crtc_mem_req = c;
    crtc_mem_addr = ga[14:0];
    @(negedge clk_sys);
    host_req = 1'b0;
    gdc_req = 1'b0;
    crtc_mem_req = 1'b0;
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    {n_mismatch, tests_run, cyc} = 0;
    {rstn, analog_variant, host_req, host_we, gdc_req, gdc_we, crtc_mem_req} = 0;
    {mon_mode, host_addr, gdc_addr, crtc_mem_addr} = 0;
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    acc(1, 0, 0, 0, 20'hA_0010, 18'h0_0000);
    chk(host_plane_re, 18'h0_0000);
    chk(config_view, 18'h0_0000);
    host.rd(3'h3);
    chk(io_rdata, 18'h0_0000);
    $display("test reset done");
    host.wr(3'h3, 8'h1F);
    acc(1, 0, 0, 0, 20'hA_0010, 18'h0_0000);
    chk(host_plane_re, 18'h0_0002);
    chk(host_phys_addr, 18'h0_8010);
    chk(config_view, 18'h0_001F);
    acc(1, 1, 1, 0, 20'hA_0010, 18'h2_0005);
    chk(host_plane_we, 18'h0_000F);
    chk(gdc_plane_we, 18'h0_000F);
    acc(1, 0, 1, 1, 20'hA_8000, 18'h2_0105);
    chk(host_hit, 18'h0_0000);
    chk(gdc_plane_re, 18'h0_0004);
    chk(gdc_phys_addr, 18'h1_0105);
    chk(crtc_phys_addr, 18'h2_0105);
    $display("test five plane done");
    host.wr(3'h3, 8'h5F);
    acc(1, 0, 0, 0, 20'hA_9000, 18'h0_0000);
    chk(host_hit, 18'h0_0001);
    chk(host_phys_addr, 18'h1_3000);
    host.wr(3'h3, 8'h9F);
    acc(1, 0, 0, 0, 20'hA_0010, 18'h0_0000);
    chk(host_hit, 18'h0_0000);
    chk(crtc_phys_valid, 18'h0_0000);
    acc(1, 1, 1, 1, 20'hA_4000, 18'h3_0100);
    chk(host_hit, 18'h0_0001);
    chk(host_plane_we, 18'h0_0007);
    chk(crtc_phys_addr, 18'h0_0100);
    host.wr(3'h3, 8'hDF);
    acc(0, 0, 0, 1, 20'h0_0000, 18'h0_0042);
    chk(crtc_phys_valid, 18'h0_0001);
    chk(crtc_phys_addr, 18'h2_0042);
    $display("test layouts done");
    for (int m = 0; m < 4; m++) begin
      mon_mode = m[1:0];
      host.wr(3'h4, 8'h00);
      host.wr(3'h5, 8'h61);
      chk(crtc_reg_data, m[0] ? 18'h0_0033 : 18'h0_0067);
    end
    host.wr(3'h4, 8'hEC);
    host.wr(3'h5, 8'hA5);
    chk(crtc_reg_idx, 18'h0_000C);
    chk(crtc_reg_data, 18'h0_00A5);
    host.wr(3'h6, 8'h00);
    host.wr(3'h7, 8'h61);
    chk(crtc_reg_data, 18'h0_0061);
    host.wr(3'h6, 8'h11);
    host.wr(3'h7, 8'h22);
    chk(crtc_reg_wr, 18'h0_0000);
    $display("test ports done");
    analog_variant = 1'b1;
    @(negedge clk_sys);
    chk(plane_colour_direct, 18'h0_0000);
    rstn = 1'b0;
    @(negedge clk_sys);
    rstn = 1'b1;
    chk(config_view, 18'h0_0000);
    $display("test misc done");
    stop_test;
  end
endmodule // dpc_plane_config_tb
